/* verilog/mms_pkg.sv */
// Shared constants and carrier types for the module management status block.
// Assumes a single 100 MHz system clock; all pins arrive from outside that domain.
package mms_pkg;

    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned CLK_NS       = 1000 / CLK_MHZ;

    // Reset pin must stay low at least this long to count as a reset
    localparam int unsigned T_RST_MIN_NS = 2000;
    localparam int unsigned RST_MIN_CYC  = (T_RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RST_CNT_W    = 8;

    // Longest allowed init time; the settle count used must not exceed it
    localparam int unsigned T_INIT_MS    = 2000;
    localparam int unsigned INIT_MAX_CYC = T_INIT_MS * CLK_MHZ * 1000;
    localparam int unsigned T_SETTLE_MS  = 10;
    localparam int unsigned INIT_DEF_CYC = T_SETTLE_MS * CLK_MHZ * 1000;
    localparam int unsigned INIT_CNT_W   = 28;

    // Synchronised pin vector positions
    localparam int unsigned PIN_RST      = 0;
    localparam int unsigned PIN_SEL      = 1;
    localparam int unsigned PIN_LP       = 2;
    localparam int unsigned PIN_SCL      = 3;
    localparam int unsigned PIN_SDA      = 4;
    localparam int unsigned NPIN         = 5;

    localparam int unsigned NLANE        = 4;
    localparam int unsigned NFLAG        = 13;

    typedef struct packed {
        logic [NLANE-1:0] other;
        logic [NLANE-1:0] tx_fault;
        logic [NLANE-1:0] rx_los;
    } mms_cond_t;

    // Latched flags: init-done event on top, then the condition flags
    typedef struct packed {
        logic      init_done;
        mms_cond_t cond;
    } mms_flags_t;

    localparam mms_flags_t FLAGS_CLR     = 13'h0000;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b001,
        ST_INIT  = 3'b010,
        ST_READY = 3'b100
    } mms_state_t;

endpackage

/* verilog/mms_status_timing.sv */
// Management status and timing logic of a four-lane pluggable module.
// Assumes the two-wire memory logic pulses i_rd_clr_stb for flag bytes read and
// presents the live mask and power-down control bits on i_mask and i_pdown.
// Contract
// - Fully functional within 2000 ms of start
// - Reset pin low at least 2 us resets
// - Two-wire bus answers within 2000 ms
// - Data-not-ready clears and interrupt asserts
// - Functional within 2000 ms after reset rise
// - Low-power pin high enters low power fast
// - Interrupt output low within 200 ms
// - Flags clear on read; interrupt releases
// - Receive loss sets bit and interrupt
// - Transmit fault sets bit and interrupt
// - Other conditions set flag and interrupt
// - Setting mask stops interrupt from flag
// - Clearing mask restores interrupt from flag
// - Select asserted enables bus responses
// - Select deasserted stops bus responses
// - Power-down bit set enters low power
// - Power-down bit cleared restores operation
// - Clear timed from SCL fall after stop
// - Mask and power-down timed likewise after stop
// - Functional means init interrupt was raised
// - Memory holds lower page and paged upper; only the lower page image is modelled, page select fixed at zero
module mms_status_timing #(
    parameter int unsigned P_INIT_CYC = mms_pkg::INIT_DEF_CYC
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_nrst,
    input  wire logic               i_reset_pin_n,
    input  wire logic               i_module_select_n,
    input  wire logic               i_low_power_pin,
    input  wire logic               i_scl,
    input  wire logic               i_sda,
    input  wire mms_pkg::mms_cond_t  i_cond,
    input  wire logic               i_rd_clr_stb,
    input  wire mms_pkg::mms_flags_t i_rd_clr_vec,
    input  wire mms_pkg::mms_flags_t i_mask,
    input  wire logic               i_pdown,
    output logic                    o_irq_out_n,
    output logic                    o_bus_enable,
    output logic                    o_low_power,
    output logic                    o_data_not_ready,
    output logic                    o_ready,
    output mms_pkg::mms_flags_t      o_flags
);

    localparam logic [mms_pkg::RST_CNT_W-1:0] RST_MIN =
        mms_pkg::RST_CNT_W'(mms_pkg::RST_MIN_CYC);
    localparam logic [mms_pkg::INIT_CNT_W-1:0] INIT_LAST =
        mms_pkg::INIT_CNT_W'(P_INIT_CYC - 1);

    // Lower page image: status byte with the data-not-ready bit, page select on top
    localparam int unsigned PAGE_BYTES = 128;
    localparam int unsigned STATUS_ADR = 2;
    localparam int unsigned PSEL_ADR   = 127;
    localparam int unsigned DNR_BIT    = 0;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [7:0]  STATUS_RST = 8'h01;
    localparam logic [7:0]  PSEL_RST   = 8'h00;

    logic [mms_pkg::NPIN-1:0]       pin_s1_r,    pin_s1_nxt;
    logic [mms_pkg::NPIN-1:0]       pin_s2_r,    pin_s2_nxt;
    logic                           scl_prev_r,  scl_prev_nxt;
    logic                           sda_prev_r,  sda_prev_nxt;
    logic                           stop_pend_r, stop_pend_nxt;
    mms_pkg::mms_flags_t             clr_pend_r,  clr_pend_nxt;
    mms_pkg::mms_flags_t             mask_r,      mask_nxt;
    logic                           pdown_r,     pdown_nxt;
    logic [mms_pkg::RST_CNT_W-1:0]  rst_cnt_r,   rst_cnt_nxt;
    logic [mms_pkg::INIT_CNT_W-1:0] init_cnt_r,  init_cnt_nxt;
    mms_pkg::mms_state_t             state_r,     state_nxt;
    mms_pkg::mms_flags_t             flags_r,     flags_nxt;
    logic                           irq_n_r,     irq_n_nxt;
    logic                           bus_en_r,    bus_en_nxt;
    logic                           lowp_r,      lowp_nxt;
    logic                           dnr_nxt;
    logic [7:0]                     page_r       [PAGE_BYTES];
    logic [7:0]                     page_nxt     [PAGE_BYTES];
    logic                           ready_r,     ready_nxt;

    logic                           scl_s, sda_s, sel_s, lp_s, rstp_s;
    logic                           stop_det, scl_fall, commit, rst_hit, init_evt;
    mms_pkg::mms_flags_t             set_vec;

    always_comb begin
        pin_s1_nxt = {i_sda, i_scl, i_low_power_pin, i_module_select_n, i_reset_pin_n};
        pin_s2_nxt = pin_s1_r;
        scl_s      = pin_s2_r[mms_pkg::PIN_SCL];
        sda_s      = pin_s2_r[mms_pkg::PIN_SDA];
        sel_s      = pin_s2_r[mms_pkg::PIN_SEL];
        lp_s       = pin_s2_r[mms_pkg::PIN_LP];
        rstp_s     = pin_s2_r[mms_pkg::PIN_RST];
        scl_prev_nxt = scl_s;
        sda_prev_nxt = sda_s;

        // Stop: SDA rises while SCL stays high; the next SCL fall commits
        stop_det = scl_s & scl_prev_r & sda_s & ~sda_prev_r;
        scl_fall = ~scl_s & scl_prev_r;
        commit   = stop_pend_r & scl_fall;
        if (stop_det) begin
            stop_pend_nxt = 1'b1;
        end else if (scl_fall) begin
            stop_pend_nxt = 1'b0;
        end else begin
            stop_pend_nxt = stop_pend_r;
        end

        // A read that lands on the commit cycle waits for the next commit
        clr_pend_nxt = commit ? mms_pkg::FLAGS_CLR : clr_pend_r;
        if (i_rd_clr_stb) begin
            clr_pend_nxt = clr_pend_nxt | i_rd_clr_vec;
        end
        mask_nxt  = commit ? i_mask : mask_r;
        pdown_nxt = commit ? i_pdown : pdown_r;

        // Low-time counter saturates so a long hold does not wrap
        if (rstp_s) begin
            rst_cnt_nxt = '0;
        end else if (rst_cnt_r != RST_MIN) begin
            rst_cnt_nxt = rst_cnt_r + 1'b1;
        end else begin
            rst_cnt_nxt = rst_cnt_r;
        end
        rst_hit = (rst_cnt_r == RST_MIN);

        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        init_evt     = 1'b0;
        case (state_r)
            mms_pkg::ST_HOLD: begin
                init_cnt_nxt = '0;
                if (rstp_s) begin
                    state_nxt = mms_pkg::ST_INIT;
                end
            end
            mms_pkg::ST_INIT: begin
                init_cnt_nxt = init_cnt_r + 1'b1;
                if (init_cnt_r == INIT_LAST) begin
                    state_nxt = mms_pkg::ST_READY;
                    init_evt  = 1'b1;
                end
            end
            mms_pkg::ST_READY: begin
                init_cnt_nxt = '0;
            end
            default: begin
                state_nxt    = mms_pkg::ST_HOLD;
                init_cnt_nxt = '0;
            end
        endcase
        if (rst_hit) begin
            state_nxt = mms_pkg::ST_HOLD;
        end

        // Conditions are only latched once monitors are valid
        set_vec.init_done = init_evt;
        set_vec.cond      = (state_r == mms_pkg::ST_READY) ? i_cond : '0;
        if (state_nxt == mms_pkg::ST_HOLD) begin
            flags_nxt = mms_pkg::FLAGS_CLR;
        end else begin
            // Set wins over a clear in the same cycle
            flags_nxt = (flags_r & ~(commit ? clr_pend_r : mms_pkg::FLAGS_CLR))
                      | set_vec;
        end

        ready_nxt  = (state_nxt == mms_pkg::ST_READY);
        dnr_nxt    = ~ready_nxt;
        irq_n_nxt  = ~(|(flags_nxt & ~mask_nxt));
        bus_en_nxt = ready_nxt & ~sel_s;
        lowp_nxt   = lp_s | pdown_nxt;
    end

    // Only the status byte and the page select (forced to PSEL_RST) are fed here; other bytes keep their reset value
    // until a page writer is attached, and the page select always reads as page zero
    always_comb begin
        for (int b = 0; b < PAGE_BYTES; b++) begin
            page_nxt[b] = page_r[b];
        end
        page_nxt[STATUS_ADR] = {7'h00, dnr_nxt};
        page_nxt[PSEL_ADR]   = PSEL_RST;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            for (int b = 0; b < PAGE_BYTES; b++) begin
                page_r[b] <= BYTE_RST;
            end
            page_r[STATUS_ADR] <= STATUS_RST;
        end else begin
            for (int b = 0; b < PAGE_BYTES; b++) begin
                page_r[b] <= page_nxt[b];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pin_s1_r    <= '0;
            pin_s2_r    <= '0;
            scl_prev_r  <= 1'b0;
            sda_prev_r  <= 1'b0;
            stop_pend_r <= 1'b0;
            clr_pend_r  <= mms_pkg::FLAGS_CLR;
            mask_r      <= mms_pkg::FLAGS_CLR;
            pdown_r     <= 1'b0;
            rst_cnt_r   <= '0;
            init_cnt_r  <= '0;
            state_r     <= mms_pkg::ST_INIT;
            flags_r     <= mms_pkg::FLAGS_CLR;
            irq_n_r     <= 1'b1;
            bus_en_r    <= 1'b0;
            lowp_r      <= 1'b0;
            ready_r     <= 1'b0;
        end else begin
            pin_s1_r    <= pin_s1_nxt;
            pin_s2_r    <= pin_s2_nxt;
            scl_prev_r  <= scl_prev_nxt;
            sda_prev_r  <= sda_prev_nxt;
            stop_pend_r <= stop_pend_nxt;
            clr_pend_r  <= clr_pend_nxt;
            mask_r      <= mask_nxt;
            pdown_r     <= pdown_nxt;
            rst_cnt_r   <= rst_cnt_nxt;
            init_cnt_r  <= init_cnt_nxt;
            state_r     <= state_nxt;
            flags_r     <= flags_nxt;
            irq_n_r     <= irq_n_nxt;
            bus_en_r    <= bus_en_nxt;
            lowp_r      <= lowp_nxt;
            ready_r     <= ready_nxt;
        end
    end

    assign o_irq_out_n      = irq_n_r;
    assign o_bus_enable     = bus_en_r;
    assign o_low_power      = lowp_r;
    assign o_data_not_ready = page_r[STATUS_ADR][DNR_BIT];
    assign o_ready          = ready_r;
    assign o_flags          = flags_r;

    // Assertions
    rst_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        rst_hit |=> (state_r == mms_pkg::ST_HOLD) && !o_ready)
        else $error("long reset pulse did not hold the module");

    init_done_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (state_r == mms_pkg::ST_INIT) && (init_cnt_r == INIT_LAST) && !rst_hit
        |=> o_ready && !o_data_not_ready && flags_r.init_done)
        else $error("init did not finish at the settle count");

    init_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_ready) && !mask_r.init_done |-> !o_irq_out_n)
        else $error("ready without init interrupt");

    irq_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ##1 (o_irq_out_n == !(|(flags_r & ~mask_r))))
        else $error("interrupt line disagrees with unmasked flags");

    flag_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        flags_r.cond.rx_los[0] && !commit && !rst_hit |=> flags_r.cond.rx_los[0])
        else $error("flag dropped without a committed read");

    los_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_ready && i_cond.rx_los[0] && !rst_hit |=> flags_r.cond.rx_los[0])
        else $error("loss of signal not latched");

    clr_commit_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        commit && clr_pend_r.cond.tx_fault[0] && !i_cond.tx_fault[0] && o_ready
        |=> !flags_r.cond.tx_fault[0])
        else $error("committed read did not clear flag");

    mask_take_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        commit |=> (mask_r == $past(i_mask)) && (pdown_r == $past(i_pdown)))
        else $error("mask or power-down not taken at commit");

    lowp_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_low_power_pin [*3] |=> o_low_power)
        else $error("low-power pin not obeyed");

    bus_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (o_ready && !i_module_select_n && !rst_hit) [*3] |=> o_bus_enable)
        else $error("selected module not answering");

    bus_desel_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_module_select_n [*3] |=> !o_bus_enable)
        else $error("deselected module still answering");

    hold_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (state_r == mms_pkg::ST_HOLD) |-> (flags_r == mms_pkg::FLAGS_CLR) && !o_bus_enable)
        else $error("held module kept flags or bus");

    quiet_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !o_ready |-> (flags_r.cond == '0))
        else $error("condition flag latched outside ready");

    tx_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_ready && i_cond.tx_fault[0] && !rst_hit |=> flags_r.cond.tx_fault[0])
        else $error("transmit fault not latched");

    other_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_ready && i_cond.other[0] && !rst_hit |=> flags_r.cond.other[0])
        else $error("other condition not latched");

    mask_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        commit && (((flags_r | set_vec) & ~i_mask) == mms_pkg::FLAGS_CLR)
        |=> o_irq_out_n)
        else $error("masked flag still drives interrupt");

    mask_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        commit && !i_mask.cond.rx_los[3] && flags_r.cond.rx_los[3]
        && !clr_pend_r.cond.rx_los[3] && !rst_hit |=> !o_irq_out_n)
        else $error("unmasked flag does not drive interrupt");

    pdown_lowp_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        pdown_r |-> o_low_power)
        else $error("power-down bit without low power");

    pdown_exit_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        commit && !i_pdown && !lp_s |=> !o_low_power)
        else $error("power-down clear did not restore power");

    bus_ready_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !o_ready |-> !o_bus_enable)
        else $error("bus enabled before ready");

    init_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (state_r == mms_pkg::ST_INIT) |-> (init_cnt_r <= INIT_LAST))
        else $error("init counter ran past its limit");

    dnr_page_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_data_not_ready != o_ready)
        else $error("data-not-ready bit disagrees with ready");

    ready_seen_c: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_ready));
    irq_clear_c:  cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_irq_out_n));
    pin_reset_c:  cover property (@(posedge i_sys_clk) disable iff (!i_nrst) rst_hit);
    pdown_c:      cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(pdown_r));
    mask_hold_c:  cover property (@(posedge i_sys_clk) disable iff (!i_nrst) commit && |i_mask);

endmodule // mms_status_timing

/* bench/mms_host_model.sv */
// Host side of the two-wire bus: makes one short frame on each rise of i_go.
// Assumes pull-ups on both lines, so both idle high and SCL stands still between frames.
module mms_host_model (
    input  wire logic i_go,
    output logic      o_done,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_scl  = 1'b1;
        o_sda  = 1'b1;
        o_done = 1'b0;
        forever begin
            @(posedge i_go);
            // Odd offset keeps SCL edges off the system clock edges
            #3;
            o_sda = 1'b0;
            #80 o_scl = 1'b0;
            #80 o_scl = 1'b1;
            #80 o_scl = 1'b0;
            #80 o_scl = 1'b1;
            // Stop, then a new start and the first SCL fall after it
            #80 o_sda = 1'b1;
            #80 o_sda = 1'b0;
            #80 o_scl = 1'b0;
            #80 o_scl = 1'b1;
            #80 o_sda = 1'b1;
            o_done = 1'b1;
            @(negedge i_go);
            o_done = 1'b0;
        end
    end
endmodule // mms_host_model

/* bench/mms_status_timing_test.sv */
// Self-checking bench for the module management status block.
// Assumes the host model supplies stop and commit edges on the two-wire lines.
module mms_status_timing_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned P_INIT = 20;

    logic                sys_clk, nrst, rst_pin_n, sel_n, lowp, stb, pdown, go, done;
    logic                scl, sda, irq_n, bus_en, low_pw, dnr, ready;
    mms_pkg::mms_cond_t  cond;
    mms_pkg::mms_flags_t vec, mask, flags, e;
    int                  err_count, checked, n;

    mms_status_timing #(.P_INIT_CYC(P_INIT)) i_mms_status_timing (
        .i_sys_clk(sys_clk), .i_nrst(nrst), .i_reset_pin_n(rst_pin_n),
        .i_module_select_n(sel_n), .i_low_power_pin(lowp), .i_scl(scl), .i_sda(sda),
        .i_cond(cond), .i_rd_clr_stb(stb), .i_rd_clr_vec(vec), .i_mask(mask),
        .i_pdown(pdown), .o_irq_out_n(irq_n), .o_bus_enable(bus_en),
        .o_low_power(low_pw), .o_data_not_ready(dnr), .o_ready(ready), .o_flags(flags)
    );

    mms_host_model i_mms_host_model (.i_go(go), .o_done(done), .o_scl(scl), .o_sda(sda));

    task automatic tally_and_finish();
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic commit();
        go = 1'b1;
        n  = 0;
        while (done !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk("frame_done", 13'h0001, {12'h000, done});
        go = 1'b0;
        // Two sync flops, commit cycle and output flop, with margin
        cyc(8);
    endtask

    task automatic rd_clr(input mms_pkg::mms_flags_t v);
        stb = 1'b1;
        vec = v;
        cyc(1);
        stb = 1'b0;
        vec = mms_pkg::FLAGS_CLR;
    endtask

    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < P_INIT + 10) begin
            cyc(1);
            n++;
        end
        chk("ready", 13'h0001, {12'h000, ready});
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        nrst      = 1'b0;
        rst_pin_n = 1'b1;
        sel_n     = 1'b1;
        lowp      = 1'b0;
        stb       = 1'b0;
        pdown     = 1'b0;
        go        = 1'b0;
        cond      = '0;
        vec       = mms_pkg::FLAGS_CLR;
        mask      = mms_pkg::FLAGS_CLR;
        cyc(5);
        chk("dnr", 13'h0001, {12'h000, dnr});
        nrst = 1'b1;
        wait_ready();
        chk("flags", 13'h1000, flags);
        chk("dnr", 13'h0000, {12'h000, dnr});
        chk("irq_n", 13'h0000, {12'h000, irq_n});
        chk("bus_en", 13'h0000, {12'h000, bus_en});
        sel_n = 1'b0;
        cyc(4);
        chk("bus_en", 13'h0001, {12'h000, bus_en});
        sel_n = 1'b1;
        cyc(4);
        chk("bus_en", 13'h0000, {12'h000, bus_en});
        rd_clr(13'h1000);
        cyc(3);
        chk("flags", 13'h1000, flags);
        commit();
        chk("flags", 13'h0000, flags);
        chk("irq_n", 13'h0001, {12'h000, irq_n});
        // One lane of each kind: receive loss, transmit fault, other
        for (int k = 0; k < 3; k++) begin
            e            = mms_pkg::FLAGS_CLR;
            e.cond[4*k]  = 1'b1;
            cond         = e.cond;
            cyc(1);
            cond = '0;
            cyc(3);
            chk("flags", e, flags);
            chk("irq_n", 13'h0000, {12'h000, irq_n});
            rd_clr(e);
            commit();
            chk("flags", 13'h0000, flags);
            chk("irq_n", 13'h0001, {12'h000, irq_n});
        end
        e                = mms_pkg::FLAGS_CLR;
        e.cond.rx_los[3] = 1'b1;
        cond             = e.cond;
        cyc(1);
        cond = '0;
        mask = e;
        commit();
        chk("irq_n", 13'h0001, {12'h000, irq_n});
        chk("flags", e, flags);
        mask = mms_pkg::FLAGS_CLR;
        commit();
        chk("irq_n", 13'h0000, {12'h000, irq_n});
        rd_clr(e);
        commit();
        chk("irq_n", 13'h0001, {12'h000, irq_n});
        lowp = 1'b1;
        cyc(4);
        chk("low_pw", 13'h0001, {12'h000, low_pw});
        lowp = 1'b0;
        cyc(4);
        chk("low_pw", 13'h0000, {12'h000, low_pw});
        pdown = 1'b1;
        commit();
        chk("low_pw", 13'h0001, {12'h000, low_pw});
        pdown = 1'b0;
        commit();
        chk("low_pw", 13'h0000, {12'h000, low_pw});
        chk("ready", 13'h0001, {12'h000, ready});
        // A pin low shorter than the minimum must be ignored
        rst_pin_n = 1'b0;
        cyc(100);
        rst_pin_n = 1'b1;
        cyc(4);
        chk("ready", 13'h0001, {12'h000, ready});
        rst_pin_n = 1'b0;
        cyc(210);
        chk("ready", 13'h0000, {12'h000, ready});
        chk("dnr", 13'h0001, {12'h000, dnr});
        rst_pin_n = 1'b1;
        wait_ready();
        chk("flags", 13'h1000, flags);
        tally_and_finish();
    end
endmodule // mms_status_timing_test
